/* include/etc_pkg.sv */
// Package for the exposure trigger controller: register map, field layout,
// trigger modes and timing constants.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package etc_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int AXI_AW = 8;
    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_DELAY = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_EXPO = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_PDOWN = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_FORCE = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_READOUT = 8'h18;
    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 2;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_ACQ_EXT_BIT = 3;
    localparam int CTRL_DOUBLE_BIT = 4;
    localparam int CTRL_TB_LSB = 8;
    localparam int CTRL_TB_W = 2;
    // STATUS fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_TRIG_BIT = 1;
    localparam int ST_EXPO_BIT = 2;
    localparam int ST_READ_BIT = 3;
    localparam int ST_PDOWN_BIT = 4;
    localparam int ST_ACQ_BIT = 5;
    localparam int FORCE_BIT = 0;
    // Timebase: 0 ns-ish (1 tick), 1 us, 2 ms units expressed in clock ticks
    localparam int TICK_NS = 50;
    localparam int US_NS = 1000;
    localparam int MS_NS = 1000000;
    localparam logic [31:0] TB_US_CYC = 32'(US_NS / TICK_NS);
    localparam logic [31:0] TB_MS_CYC = 32'(MS_NS / TICK_NS);
    localparam logic [31:0] ONE_CYC = 32'h0000_0001;
    // Power-down threshold applies above one second of exposure
    localparam int PDOWN_MIN_S = 1;
    localparam logic [63:0] PDOWN_MIN_CYC = 64'(PDOWN_MIN_S) * 64'(CLK_HZ);
    localparam logic [31:0] RESP_OKAY = 32'h0;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ETC_MODE_AUTO,
        ETC_MODE_SOFT,
        ETC_MODE_EDGE,
        ETC_MODE_PULSE
    } etc_mode_t;
endpackage

/* logic/etc_top.sv */
// Exposure trigger controller: trigger modes, busy tracking, double image.
// Assumes a 20 MHz clock, synchronous active-high reset, AXI4-Lite master,
// asynchronous trigger, gate and polarity switch pins.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Four trigger modes, host writable and readable
// - Force starts exposure in auto/soft/edge modes
// - Force ignored in pulse-width mode
// - Triggers discarded while busy
// - Busy readable; host checks before forcing
// - Power-down threshold only above one second
// - Host reads logical trigger input level
// - Edge polarity from static switch
// - Polarity maps pin level to TRUE/FALSE
// - Double image: mode governs first exposure only
// - Second exposure lasts first readout time
// - Auto mode restarts exposure after readout
// - Soft mode ignores trigger input
// - Edge mode: edge or force starts delay
// - Pulse mode exposes while input active
// - Pulse mode ignores delay and exposure times
// - Delay and exposure held with timebase
// - Triggers only in run; stop halts all
// - External gate blocks triggers and readout
module etc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [etc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [etc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_pin,
    input wire logic trig_falling_sw,
    input wire logic acq_pin,
    output logic exposing,
    output logic reading,
    output logic busy
);
    import etc_pkg::*;

    typedef enum logic [2:0] {
        ETC_IDLE, ETC_DELAY, ETC_EXPO, ETC_EXPO2, ETC_READ
    } etc_state_t;

    function automatic logic [31:0] etc_scale(input logic [31:0] val, input logic [1:0] tb);
        logic [31:0] unit;
        unit = (tb == 2'h1) ? TB_US_CYC : (tb == 2'h2) ? TB_MS_CYC : ONE_CYC;
        return 32'(val * unit);
    endfunction

    // Pin synchronisers
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    logic pol_s1_q, pol_s2_q;
    logic acq_s1_q, acq_s2_q;
    always_ff @(posedge clk) begin
        trig_s1_q <= trig_pin;
        trig_s2_q <= trig_s1_q;
        trig_s3_q <= trig_s2_q;
        pol_s1_q <= trig_falling_sw;
        pol_s2_q <= pol_s1_q;
        acq_s1_q <= acq_pin;
        acq_s2_q <= acq_s1_q;
    end

    // Registers
    logic [31:0] ctrl_q, delay_q, expo_q, pdown_q, readout_q;
    logic force_pulse;
    logic [1:0] mode;
    logic run, acq_ext, dbl;
    logic [1:0] tb;
    assign mode = ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W];
    assign run = ctrl_q[CTRL_RUN_BIT];
    assign acq_ext = ctrl_q[CTRL_ACQ_EXT_BIT];
    assign dbl = ctrl_q[CTRL_DOUBLE_BIT];
    assign tb = ctrl_q[CTRL_TB_LSB +: CTRL_TB_W];

    // Logical trigger level and selected edge
    wire trig_true = trig_s2_q ^ pol_s2_q;
    wire trig_prev = trig_s3_q ^ pol_s2_q;
    wire trig_edge = trig_true & ~trig_prev;
    wire acq_ok = ~acq_ext | acq_s2_q;
    wire enabled = run & acq_ok;

    etc_state_t st_q;
    logic [31:0] cnt_q;
    logic [31:0] rd_len_q;
    logic second_q;
    logic pdown_q_act;
    wire idle = (st_q == ETC_IDLE);
    // Start condition per mode, only when idle; triggers while busy are dropped
    wire is_pulse = (mode == ETC_MODE_PULSE);
    wire sw_start = force_pulse & ~is_pulse;
    wire ext_start = (mode == ETC_MODE_EDGE) & trig_edge;
    wire auto_start = (mode == ETC_MODE_AUTO);
    wire pulse_start = is_pulse & trig_edge;
    wire start = idle & enabled & (sw_start | ext_start | auto_start | pulse_start);
    wire [31:0] dly_cyc = etc_scale(delay_q, tb);
    wire [31:0] exp_cyc = etc_scale(expo_q, tb);
    wire long_expo = 64'(exp_cyc) > PDOWN_MIN_CYC;
    wire cnt_done = (cnt_q <= ONE_CYC);

    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            st_q <= ETC_IDLE;
            cnt_q <= '0;
            second_q <= 1'b0;
        end else begin
            case (st_q)
                ETC_IDLE: begin
                    second_q <= 1'b0;
                    if (start) begin
                        if (is_pulse) begin
                            st_q <= ETC_EXPO;
                        end else if (dly_cyc != 32'h0) begin
                            st_q <= ETC_DELAY;
                            cnt_q <= dly_cyc;
                        end else begin
                            st_q <= ETC_EXPO;
                            cnt_q <= exp_cyc;
                        end
                    end
                end
                ETC_DELAY: begin
                    cnt_q <= cnt_q - ONE_CYC;
                    if (cnt_done) begin
                        st_q <= ETC_EXPO;
                        cnt_q <= exp_cyc;
                    end
                end
                ETC_EXPO: begin
                    cnt_q <= cnt_q - ONE_CYC;
                    if (is_pulse ? !trig_true : cnt_done) begin
                        st_q <= ETC_READ;
                        cnt_q <= rd_len_q;
                        second_q <= dbl;
                    end
                end
                ETC_READ: begin
                    if (acq_ok) begin
                        cnt_q <= cnt_q - ONE_CYC;
                        if (cnt_done) begin
                            st_q <= ETC_IDLE;
                            second_q <= 1'b0;
                        end
                    end
                end
                default: st_q <= ETC_IDLE;
            endcase
        end
    end

    // Power-down status, registered: set while a timed exposure longer than one second runs
    always_ff @(posedge clk) begin
        pdown_q_act <= (sys_rst) ? 1'b0 : (long_expo & (st_q == ETC_EXPO) & ~is_pulse);
    end

    assign exposing = (st_q == ETC_EXPO) | ((st_q == ETC_READ) & second_q);
    assign reading = (st_q == ETC_READ);
    assign busy = ~idle;

    // AXI4-Lite slave
    logic aw_q, w_q, bv_q, rv_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [1:0] bresp_q, rresp_q;
    assign s_axi_awready = ~aw_q & ~bv_q;
    assign s_axi_wready = ~w_q & ~bv_q;
    assign s_axi_arready = ~rv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    wire aw_have = aw_q | (s_axi_awvalid & s_axi_awready);
    wire w_have = w_q | (s_axi_wvalid & s_axi_wready);
    wire [AXI_AW-1:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
    wire do_wr = aw_have & w_have & ~bv_q;
    wire wr_hit = (wa == OFS_CTRL) | (wa == OFS_DELAY) | (wa == OFS_EXPO) | (wa == OFS_PDOWN) |
                  (wa == OFS_FORCE) | (wa == OFS_READOUT) | (wa == OFS_STATUS);
    assign force_pulse = do_wr & (wa == OFS_FORCE) & wd[FORCE_BIT];
    wire [31:0] status = 32'({acq_s2_q, pdown_q_act, reading, exposing, trig_true, busy});
    wire [31:0] rmux = (s_axi_araddr == OFS_CTRL) ? ctrl_q :
                       (s_axi_araddr == OFS_DELAY) ? delay_q :
                       (s_axi_araddr == OFS_EXPO) ? expo_q :
                       (s_axi_araddr == OFS_PDOWN) ? pdown_q :
                       (s_axi_araddr == OFS_READOUT) ? readout_q :
                       (s_axi_araddr == OFS_STATUS) ? status : RESP_OKAY;
    wire rd_hit = (s_axi_araddr == OFS_CTRL) | (s_axi_araddr == OFS_DELAY) | (s_axi_araddr == OFS_EXPO) |
                  (s_axi_araddr == OFS_PDOWN) | (s_axi_araddr == OFS_READOUT) |
                  (s_axi_araddr == OFS_STATUS) | (s_axi_araddr == OFS_FORCE);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            bresp_q <= AXI_OKAY;
            rresp_q <= AXI_OKAY;
            ctrl_q <= '0;
            delay_q <= '0;
            expo_q <= '0;
            pdown_q <= '0;
            readout_q <= '0;
        end else begin
            if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bv_q <= 1'b1;
                bresp_q <= wr_hit ? AXI_OKAY : AXI_SLVERR;
                if (wa == OFS_CTRL) ctrl_q <= wd;
                if (wa == OFS_DELAY) delay_q <= wd;
                if (wa == OFS_EXPO) expo_q <= wd;
                if (wa == OFS_PDOWN) pdown_q <= wd;
                if (wa == OFS_READOUT) readout_q <= wd;
            end else if (bv_q & s_axi_bready) begin
                bv_q <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                rv_q <= 1'b1;
                rdata_q <= rmux;
                rresp_q <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (rv_q & s_axi_rready) begin
                rv_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        rd_len_q <= sys_rst ? ONE_CYC : ((readout_q == 32'h0) ? ONE_CYC : readout_q);
    end

    a_force_pulse_noact: assert property (@(posedge clk) disable iff (sys_rst)
        (idle & is_pulse & force_pulse & ~trig_edge) |=> idle)
        else $error("force acted in pulse mode");
    a_busy_drop_trig: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q == ETC_READ & force_pulse) |=> (st_q != ETC_DELAY))
        else $error("trigger accepted while busy");
    a_force_starts: assert property (@(posedge clk) disable iff (sys_rst)
        (idle & run & acq_ok & force_pulse & ~is_pulse) |=> busy)
        else $error("force did not start exposure");
    a_stop_halts: assert property (@(posedge clk) disable iff (sys_rst)
        !run |=> idle)
        else $error("sequence runs in stop state");
    a_gate_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        (idle & acq_ext & ~acq_s2_q) |=> idle)
        else $error("trigger taken while gate false");
    a_soft_no_ext: assert property (@(posedge clk) disable iff (sys_rst)
        (idle & mode == ETC_MODE_SOFT & ~force_pulse) |=> idle)
        else $error("soft mode started without force");
    a_pulse_end: assert property (@(posedge clk) disable iff (sys_rst)
        (run & st_q == ETC_EXPO & is_pulse & ~trig_true) |=> (st_q == ETC_READ))
        else $error("pulse exposure did not end");
    a_auto_restart: assert property (@(posedge clk) disable iff (sys_rst)
        (idle & run & acq_ok & mode == ETC_MODE_AUTO) |=> busy)
        else $error("auto mode did not restart");
    a_level_map: assert property (@(posedge clk) disable iff (sys_rst)
        status[ST_TRIG_BIT] == (trig_s2_q != pol_s2_q))
        else $error("trigger level mapping wrong");
    a_pulse_no_delay: assert property (@(posedge clk) disable iff (sys_rst)
        (start & is_pulse) |=> (st_q == ETC_EXPO))
        else $error("pulse mode entered delay");
    a_edge_needs_trig: assert property (@(posedge clk) disable iff (sys_rst)
        (idle & mode == ETC_MODE_EDGE & ~trig_edge & ~force_pulse) |=> idle)
        else $error("edge mode started without trigger");
    a_gate_freeze: assert property (@(posedge clk) disable iff (sys_rst)
        (run & st_q == ETC_READ & acq_ext & ~acq_s2_q) |=> (st_q == ETC_READ && $stable(cnt_q)))
        else $error("readout ran while gate false");
    a_pdown_long: assert property (@(posedge clk) disable iff (sys_rst)
        pdown_q_act |-> $past(long_expo))
        else $error("power-down without long exposure");
    a_double_second: assert property (@(posedge clk) disable iff (sys_rst)
        (run & st_q == ETC_EXPO & dbl & (is_pulse ? !trig_true : cnt_done)) |=> (exposing & reading))
        else $error("second exposure missing in readout");
endmodule // etc_top

`default_nettype wire

/* testbench/etc_trig_src.sv */
// External trigger source model: turns the bench's logical trigger level into a pin level.
// Assumes the polarity switch seen by the design is the one given here.
`timescale 1ns/100ps
`default_nettype none
module etc_trig_src (
    input wire logic level,
    input wire logic falling_sw,
    output logic trig_pin
);
    // With falling polarity a low pin is the TRUE level
    assign trig_pin = level ^ falling_sw;
endmodule // etc_trig_src
`default_nettype wire

/* testbench/test_exposure_trigger_control.sv */
// Self-checking bench for the exposure trigger controller, one task per scenario.
// Assumes etc_pkg and the source model etc_trig_src are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_exposure_trigger_control;
    import etc_pkg::*;
    localparam int EXP_N = 4;
    localparam int RD_N = 6;
    logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, trig_act, trig_falling_sw, acq_pin;
    logic awready, wready, bvalid, arready, rvalid, trig_pin, exposing, reading, busy;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int error_cnt, n_tests, cyc, rd_cyc;
    etc_top i_etc_top (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_pin(trig_pin),
        .trig_falling_sw(trig_falling_sw), .acq_pin(acq_pin), .exposing(exposing), .reading(reading),
        .busy(busy));
    etc_trig_src i_etc_trig_src (.level(trig_act), .falling_sw(trig_falling_sw), .trig_pin(trig_pin));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Ready and valid are stable between edges, so they are sampled at the falling edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(name, d & m, e);
    endtask
    // Counts busy and exposing cycles of the next sequence; zero if none starts within 40 cycles
    task automatic measure(output int b, output int e);
        int n;
        b = 0;
        e = 0;
        n = 0;
        rd_cyc = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'b1 && n < 40);
        while (busy === 1'b1) begin
            b++;
            e += int'(exposing);
            rd_cyc += int'(reading);
            @(negedge clk);
        end
        @(posedge clk);
    endtask
    task automatic force_meas(output int b, output int e);
        fork
            measure(b, e);
            wr(OFS_FORCE, 32'h0000_0001);
        join
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 32'(m));
            rd_chk("mode", OFS_CTRL, 32'h0000_031F, 32'(m));
        end
        wr(OFS_DELAY, 32'h0000_0123);
        rd_chk("delay", OFS_DELAY, 32'hFFFF_FFFF, 32'h0000_0123);
        wr(OFS_PDOWN, 32'h0000_0ABC);
        rd_chk("pdown", OFS_PDOWN, 32'hFFFF_FFFF, 32'h0000_0ABC);
        wr(OFS_EXPO, 32'h0000_03E9);
        wr(OFS_DELAY, 32'h0);
        wr(OFS_CTRL, 32'h0000_0205);
        rd_chk("ms timebase", OFS_CTRL, 32'h0000_0300, 32'h0000_0200);
        // Power-down shows only while a long timed exposure runs
        wr(OFS_FORCE, 32'h0000_0001);
        rd_chk("long expo", OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
        wr(OFS_EXPO, 32'h0000_03E8);
        rd_chk("one second", OFS_STATUS, 32'h0000_0010, 32'h0);
        wr(OFS_CTRL, 32'h0);
        axi_wr(8'h1C, 32'h0000_0001, r);
        check("unmapped write", 32'(r), 32'(AXI_SLVERR));
        axi_rd(8'h1C, d, r);
        check("unmapped read", 32'(r), 32'(AXI_SLVERR));
        wr(OFS_EXPO, 32'(EXP_N));
        $display("test regs done");
    endtask
    task automatic t_soft();
        int b, e;
        wr(OFS_CTRL, 32'h0000_0005);
        trig_act <= 1'b1;
        repeat (8) @(posedge clk);
        trig_act <= 1'b0;
        rd_chk("pin ignored", OFS_STATUS, 32'h0000_0001, 32'h0);
        force_meas(b, e);
        check("soft busy", 32'(b), 32'(EXP_N + RD_N));
        check("soft expo", 32'(e), 32'(EXP_N));
        check("soft read", 32'(rd_cyc), 32'(RD_N));
        wr(OFS_FORCE, 32'h0000_0001);
        rd_chk("busy status", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr(OFS_FORCE, 32'h0000_0001);
        repeat (5) @(posedge clk);
        rd_chk("force while busy", OFS_STATUS, 32'h0000_0001, 32'h0);
        $display("test soft done");
    endtask
    task automatic t_pulse();
        int b, e;
        wr(OFS_DELAY, 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0007);
        force_meas(b, e);
        check("pulse force", 32'(b), 32'h0);
        fork
            measure(b, e);
            begin
                trig_act <= 1'b1;
                repeat (20) @(posedge clk);
                trig_act <= 1'b0;
            end
        join
        check("pulse width", 32'(e >= 20 && e <= 21), 32'h1);
        check("pulse no delay", 32'(b), 32'(e + RD_N));
        $display("test pulse done");
    endtask
    task automatic t_edge();
        int b, e;
        trig_falling_sw <= 1'b1;
        wr(OFS_DELAY, 32'h0000_0003);
        repeat (4) @(posedge clk);
        rd_chk("level false", OFS_STATUS, 32'h0000_0002, 32'h0);
        wr(OFS_CTRL, 32'h0000_0006);
        fork
            measure(b, e);
            trig_act <= 1'b1;
        join
        check("edge busy", 32'(b), 32'(3 + EXP_N + RD_N));
        check("edge expo", 32'(e), 32'(EXP_N));
        rd_chk("level true", OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        fork
            measure(b, e);
            trig_act <= 1'b0;
        join
        check("wrong edge", 32'(b), 32'h0);
        wr(OFS_DELAY, 32'h0);
        wr(OFS_CTRL, 32'h0000_0001);
        trig_falling_sw <= 1'b0;
        $display("test edge done");
    endtask
    task automatic t_gate();
        int b, e;
        force_meas(b, e);
        check("stopped", 32'(b), 32'h0);
        wr(OFS_CTRL, 32'h0000_000D);
        force_meas(b, e);
        check("gate false", 32'(b), 32'h0);
        acq_pin <= 1'b1;
        repeat (4) @(posedge clk);
        force_meas(b, e);
        check("gate true", 32'(b), 32'(EXP_N + RD_N));
        // Gate dropped during readout must freeze the readout
        wr(OFS_FORCE, 32'h0000_0001);
        repeat (4) @(posedge clk);
        acq_pin <= 1'b0;
        repeat (20) @(posedge clk);
        rd_chk("readout halted", OFS_STATUS, 32'h0000_0009, 32'h0000_0009);
        acq_pin <= 1'b1;
        repeat (12) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0005);
        wr(OFS_FORCE, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0001);
        rd_chk("stop halts", OFS_STATUS, 32'h0000_0001, 32'h0);
        $display("test gate done");
    endtask
    task automatic t_double_auto();
        int b, e;
        logic p;
        wr(OFS_CTRL, 32'h0000_0015);
        force_meas(b, e);
        check("second expo", 32'(e), 32'(EXP_N + RD_N));
        wr(OFS_CTRL, 32'h0000_0004);
        e = 0;
        p = 1'b0;
        repeat (60) begin
            @(negedge clk);
            e += int'(exposing & !p);
            p = exposing;
        end
        @(posedge clk);
        check("auto restarts", 32'(e >= 4), 32'h1);
        wr(OFS_CTRL, 32'h0);
        $display("test double and auto done");
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("Error timeout expected finish seen hang");
            end_of_test();
        end
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, trig_act, trig_falling_sw, acq_pin} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        // Responses are always accepted, so back-to-back calls never toggle ready
        bready = 1'b1;
        rready = 1'b1;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        wr(OFS_READOUT, 32'(RD_N));
        t_regs();
        t_soft();
        t_pulse();
        t_edge();
        t_gate();
        t_double_auto();
        end_of_test();
    end
endmodule // test_exposure_trigger_control
`default_nettype wire
